// File: logic/tmw_params.svh
`ifndef TMW_PARAMS_SVH
`define TMW_PARAMS_SVH

// register byte offsets
`define TMW_OFF_CTRL      5'h00
`define TMW_OFF_COUNT     5'h04
`define TMW_OFF_CMP_A     5'h08
`define TMW_OFF_CMP_B     5'h0C
`define TMW_OFF_CMP_C     5'h10
`define TMW_OFF_CAPTURE   5'h14
`define TMW_OFF_FLAGS     5'h18

// control register fields
`define TMW_CTRL_MODE_LSB 0
`define TMW_CTRL_MODE_MSB 3
`define TMW_CTRL_CSEL_LSB 4
`define TMW_CTRL_CSEL_MSB 6
`define TMW_CTRL_COM_LSB  8
`define TMW_CTRL_USED_MSB 13

// flag register bit positions
`define TMW_FLG_OVF       0
`define TMW_FLG_CMP_A     1
`define TMW_FLG_CAPTURE   4

// waveform mode codes and the ceiling source bit
`define TMW_MODE_NORMAL   4'h0
`define TMW_MODE_CTC_A    4'h4
`define TMW_MODE_FAST8    4'h5
`define TMW_MODE_FAST9    4'h6
`define TMW_MODE_FAST10   4'h7
`define TMW_MODE_CTC_CAP  4'hC
`define TMW_MODE_FASTCAP  4'hE
`define TMW_MODE_FASTA    4'hF
`define TMW_MODE_TOPSRC   3

// fixed ceilings and floor
`define TMW_MAX           16'hFFFF
`define TMW_FLOOR         16'h0000
`define TMW_TOP8          16'h00FF
`define TMW_TOP9          16'h01FF
`define TMW_TOP10         16'h03FF

// count clock select codes
`define TMW_CSEL_STOP     3'h0
`define TMW_CSEL_DIV1     3'h1
`define TMW_CSEL_DIV8     3'h2
`define TMW_CSEL_DIV64    3'h3
`define TMW_CSEL_DIV256   3'h4
`define TMW_CSEL_DIV1024  3'h5
`define TMW_CSEL_EXT_RISE 3'h6
`define TMW_CSEL_EXT_FALL 3'h7

// prescaler terminal counts (divisor minus one)
`define TMW_PRE_T1        10'h000
`define TMW_PRE_T8        10'h007
`define TMW_PRE_T64       10'h03F
`define TMW_PRE_T256      10'h0FF
`define TMW_PRE_T1024     10'h3FF

// compare output mode codes
`define TMW_COM_OFF       2'h0
`define TMW_COM_TOGGLE    2'h1
`define TMW_COM_CLEAR     2'h2
`define TMW_COM_SET       2'h3

// axi responses
`define TMW_RESP_OKAY     2'h0
`define TMW_RESP_SLVERR   2'h2

`endif

// File: logic/tmw_pkg.sv
package tmw_pkg;

  // complete state of the timer, registered in one flop bank
  typedef struct packed {
    logic [15:0]       cnt;      // count_register
    logic [2:0][15:0]  ocr_buf;  // software-visible compare values
    logic [2:0][15:0]  ocr_act;  // values the comparators use
    logic [15:0]       cap;      // capture_register
    logic [3:0]        mode;     // waveform_mode_sel
    logic [2:0]        csel;     // count clock select
    logic [2:0][1:0]   com;      // compare_output_mode per channel
    logic [4:0]        flags;    // overflow, compare a/b/c, capture
    logic [9:0]        presc;    // prescale divider
    logic              ext_s1;   // external clock sync stage 1
    logic              ext_s2;   // external clock sync stage 2
    logic              ext_s3;   // edge detect history
    logic [2:0]        wave;     // wave_out_a..c
    logic              aw_rdy;   // awready and wready
    logic              bvalid;   // write response valid
    logic [1:0]        bresp;    // write response code
    logic              ar_rdy;   // arready
    logic              rvalid;   // read data valid
    logic [31:0]       rdata;    // read data
    logic [1:0]        rresp;    // read response code
  } tmw_state_t;

endpackage

// File: logic/tmw_timer.sv
`include "tmw_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tmw_timer
  import tmw_pkg::*;
(
  input  wire logic        clk_sys,        // system clock, 10 MHz
  input  wire logic        nrst,           // async reset, active low
  input  wire logic        ext_clk_pin,    // external count clock pin
  input  wire logic [4:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // write byte enables
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [4:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  output logic             wave_out_a,     // waveform output a
  output logic             wave_out_b,     // waveform output b
  output logic             wave_out_c      // waveform output c
);

  tmw_state_t st;       // registered state
  tmw_state_t next_st;  // next state

  // register decode shared by read and write paths; 7 means unmapped
  function automatic logic [2:0] reg_sel(input logic [4:0] addr);
    unique case (addr)
      `TMW_OFF_CTRL:    reg_sel = 3'h0;
      `TMW_OFF_COUNT:   reg_sel = 3'h1;
      `TMW_OFF_CMP_A:   reg_sel = 3'h2;
      `TMW_OFF_CMP_B:   reg_sel = 3'h3;
      `TMW_OFF_CMP_C:   reg_sel = 3'h4;
      `TMW_OFF_CAPTURE: reg_sel = 3'h5;
      `TMW_OFF_FLAGS:   reg_sel = 3'h6;
      default:          reg_sel = 3'h7;
    endcase
  endfunction

  // merge write data into an old value under the byte enables
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction

  // terminal count of the prescaler for each internal selection
  function automatic logic [9:0] pre_term(input logic [2:0] sel);
    unique case (sel)
      `TMW_CSEL_DIV8:    pre_term = `TMW_PRE_T8;
      `TMW_CSEL_DIV64:   pre_term = `TMW_PRE_T64;
      `TMW_CSEL_DIV256:  pre_term = `TMW_PRE_T256;
      `TMW_CSEL_DIV1024: pre_term = `TMW_PRE_T1024;
      default:           pre_term = `TMW_PRE_T1;
    endcase
  endfunction

  // mode classification
  logic        is_ctc;   // clear-on-match mode
  logic        is_pwm;   // single-slope pwm mode
  logic [15:0] top;      // active ceiling
  logic        tick;     // one count clock
  logic        at_top;   // count equals ceiling this tick
  logic [2:0]  wsel;     // decoded write register
  logic [2:0]  rsel;     // decoded read register
  logic        wr_go;    // write handshake cycle
  logic        rd_go;    // read handshake cycle
  logic [31:0] wval;     // merged write value
  logic [31:0] ctrl_rd;  // control register image

  // decode of the mode field and the ceiling it selects
  always_comb begin
    is_ctc = (st.mode == `TMW_MODE_CTC_A) || (st.mode == `TMW_MODE_CTC_CAP);
    is_pwm = (st.mode == `TMW_MODE_FAST8) || (st.mode == `TMW_MODE_FAST9)
          || (st.mode == `TMW_MODE_FAST10) || (st.mode == `TMW_MODE_FASTCAP)
          || (st.mode == `TMW_MODE_FASTA);
    unique case (st.mode)
      `TMW_MODE_FAST8:   top = `TMW_TOP8;
      `TMW_MODE_FAST9:   top = `TMW_TOP9;
      `TMW_MODE_FAST10:  top = `TMW_TOP10;
      `TMW_MODE_FASTCAP: top = st.cap;
      `TMW_MODE_FASTA:   top = st.ocr_act[0];
      `TMW_MODE_CTC_A:   top = st.ocr_act[0];
      `TMW_MODE_CTC_CAP: top = st.cap;
      default:           top = `TMW_MAX;
    endcase
    at_top = (is_ctc || is_pwm) && (st.cnt == top);
  end

  // count clock: prescaler terminal count or synchronised pin edge
  always_comb begin
    unique case (st.csel)
      `TMW_CSEL_STOP:     tick = 1'b0;
      `TMW_CSEL_EXT_RISE: tick = st.ext_s2 && !st.ext_s3;
      `TMW_CSEL_EXT_FALL: tick = !st.ext_s2 && st.ext_s3;
      default:            tick = (st.presc == pre_term(st.csel));
    endcase
  end

  // bus decode helpers
  always_comb begin
    wsel    = reg_sel(s_axi_awaddr);
    rsel    = reg_sel(s_axi_araddr);
    wr_go   = st.aw_rdy;
    rd_go   = st.ar_rdy;
    ctrl_rd = '0;
    ctrl_rd[`TMW_CTRL_MODE_MSB:`TMW_CTRL_MODE_LSB] = st.mode;
    ctrl_rd[`TMW_CTRL_CSEL_MSB:`TMW_CTRL_CSEL_LSB] = st.csel;
    ctrl_rd[`TMW_CTRL_USED_MSB:`TMW_CTRL_COM_LSB]  = st.com;
    unique case (wsel)
      3'h0:    wval = merge(ctrl_rd, s_axi_wdata, s_axi_wstrb);
      3'h1:    wval = merge({16'h0000, st.cnt}, s_axi_wdata, s_axi_wstrb);
      3'h2:    wval = merge({16'h0000, st.ocr_buf[0]}, s_axi_wdata, s_axi_wstrb);
      3'h3:    wval = merge({16'h0000, st.ocr_buf[1]}, s_axi_wdata, s_axi_wstrb);
      3'h4:    wval = merge({16'h0000, st.ocr_buf[2]}, s_axi_wdata, s_axi_wstrb);
      3'h5:    wval = merge({16'h0000, st.cap}, s_axi_wdata, s_axi_wstrb);
      default: wval = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
    endcase
  end

  // next-state logic: counter, compare units, flags, bus slave
  always_comb begin
    logic [4:0] set_f;  // flags raised by hardware this cycle
    logic [4:0] clr_f;  // flags cleared by software this cycle
    set_f   = '0;
    clr_f   = '0;
    next_st = st;

    // pin synchroniser; only stage two feeds the edge detector
    next_st.ext_s1 = ext_clk_pin;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_s3 = st.ext_s2;

    // prescaler runs only while an internal divide is selected
    if (tick || st.csel == `TMW_CSEL_STOP || st.csel == `TMW_CSEL_EXT_RISE
        || st.csel == `TMW_CSEL_EXT_FALL) begin
      next_st.presc = '0;
    end else begin
      next_st.presc = st.presc + 10'h001;
    end

    if (tick) begin
      // compare units see the count held before this tick
      for (int i = 0; i < 3; i++) begin
        if (st.cnt == st.ocr_act[i]) begin
          set_f[`TMW_FLG_CMP_A + i] = 1'b1;
          if (is_pwm) begin
            unique case (st.com[i])
              `TMW_COM_CLEAR: next_st.wave[i] = 1'b0;
              `TMW_COM_SET:   next_st.wave[i] = 1'b1;
              `TMW_COM_TOGGLE: begin
                // toggle only exists for channel a with a as ceiling
                if (i == 0 && st.mode == `TMW_MODE_FASTA) begin
                  next_st.wave[i] = !st.wave[i];
                end
              end
              default: ;
            endcase
          end else begin
            unique case (st.com[i])
              `TMW_COM_TOGGLE: next_st.wave[i] = !st.wave[i];
              `TMW_COM_CLEAR:  next_st.wave[i] = 1'b0;
              `TMW_COM_SET:    next_st.wave[i] = 1'b1;
              default: ;
            endcase
          end
        end
        // counter clearing restores the opposite level; applied after the
        // match so a compare equal to the ceiling holds the output steady
        if (is_pwm && at_top) begin
          if (st.com[i] == `TMW_COM_CLEAR) next_st.wave[i] = 1'b1;
          if (st.com[i] == `TMW_COM_SET)   next_st.wave[i] = 1'b0;
        end
      end

      if (at_top) begin
        next_st.cnt = `TMW_FLOOR;
        if (is_pwm) begin
          set_f[`TMW_FLG_OVF] = 1'b1;
          next_st.ocr_act     = st.ocr_buf;
        end else if (st.mode[`TMW_MODE_TOPSRC]) begin
          set_f[`TMW_FLG_CAPTURE] = 1'b1;
        end else begin
          set_f[`TMW_FLG_CMP_A] = 1'b1;
        end
      end else begin
        // a ceiling below the count is passed and reached after the wrap
        next_st.cnt = st.cnt + 16'h0001;
        if (st.cnt == `TMW_MAX && !is_pwm) begin
          set_f[`TMW_FLG_OVF] = 1'b1;
        end
      end
    end

    // write channel: address and data are taken together in one cycle
    next_st.aw_rdy = s_axi_awvalid && s_axi_wvalid && !st.aw_rdy && !st.bvalid;
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = (wsel == 3'h7) ? `TMW_RESP_SLVERR : `TMW_RESP_OKAY;
      unique case (wsel)
        3'h0: begin
          next_st.mode = wval[`TMW_CTRL_MODE_MSB:`TMW_CTRL_MODE_LSB];
          next_st.csel = wval[`TMW_CTRL_CSEL_MSB:`TMW_CTRL_CSEL_LSB];
          next_st.com  = wval[`TMW_CTRL_USED_MSB:`TMW_CTRL_COM_LSB];
        end
        3'h1: next_st.cnt = wval[15:0];
        3'h2, 3'h3, 3'h4: begin
          next_st.ocr_buf[wsel - 3'h2] = wval[15:0];
          // only the fast pwm modes defer the new value to the ceiling
          if (!is_pwm) begin
            next_st.ocr_act[wsel - 3'h2] = wval[15:0];
          end
        end
        3'h5: next_st.cap = wval[15:0];
        3'h6: clr_f = wval[4:0];
        default: ;
      endcase
    end

    // a flag raised in the cycle it is cleared stays raised
    next_st.flags = (st.flags & ~clr_f) | set_f;

    // read channel
    next_st.ar_rdy = s_axi_arvalid && !st.ar_rdy && !st.rvalid;
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (rd_go) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = (rsel == 3'h7) ? `TMW_RESP_SLVERR : `TMW_RESP_OKAY;
      unique case (rsel)
        3'h0:    next_st.rdata = ctrl_rd;
        3'h1:    next_st.rdata = {16'h0000, st.cnt};
        3'h2:    next_st.rdata = {16'h0000, st.ocr_buf[0]};
        3'h3:    next_st.rdata = {16'h0000, st.ocr_buf[1]};
        3'h4:    next_st.rdata = {16'h0000, st.ocr_buf[2]};
        3'h5:    next_st.rdata = {16'h0000, st.cap};
        3'h6:    next_st.rdata = {27'h0000000, st.flags};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // single flop bank; everything zero after reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the flop bank
  assign s_axi_awready = st.aw_rdy;
  assign s_axi_wready  = st.aw_rdy;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.ar_rdy;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign wave_out_a    = st.wave[0];
  assign wave_out_b    = st.wave[1];
  assign wave_out_c    = st.wave[2];

  // checks
  AST_NORMAL_WRAP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && st.mode == `TMW_MODE_NORMAL && st.cnt == `TMW_MAX
     && !(wr_go && wsel == 3'h1))
    |=> (st.cnt == `TMW_FLOOR) && st.flags[`TMW_FLG_OVF])
    else $error("normal mode did not wrap with overflow");
  AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && !at_top && !(wr_go && wsel == 3'h1))
    |=> st.cnt == $past(st.cnt) + 16'h0001)
    else $error("count did not advance by one");
  AST_CTC_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && is_ctc && st.cnt == top && !(wr_go && wsel == 3'h1))
    |=> st.cnt == `TMW_FLOOR)
    else $error("clear-on-match did not clear at ceiling");
  AST_CTC_FLAG_A: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && st.mode == `TMW_MODE_CTC_A && st.cnt == st.ocr_act[0])
    |=> st.flags[`TMW_FLG_CMP_A])
    else $error("compare a flag missed at ceiling");
  AST_PWM_LOAD: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && is_pwm && at_top && !wr_go)
    |=> (st.ocr_act == $past(st.ocr_buf)) && st.flags[`TMW_FLG_OVF])
    else $error("ceiling did not load buffers and set overflow");
  AST_TOGGLE_A: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && st.mode == `TMW_MODE_NORMAL && st.com[0] == `TMW_COM_TOGGLE
     && st.cnt == st.ocr_act[0])
    |=> wave_out_a != $past(wave_out_a))
    else $error("output a did not toggle on match");
  AST_CTC_IMMEDIATE: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wr_go && wsel == 3'h2 && is_ctc && s_axi_wstrb == 4'hF)
    |=> st.ocr_act[0] == $past(s_axi_wdata[15:0]))
    else $error("compare a write not immediate");
  AST_DIV8_GAP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && st.csel == `TMW_CSEL_DIV8 && !wr_go)
    |=> (!tick) [*7] ##1 (tick || st.csel != `TMW_CSEL_DIV8))
    else $error("divide by eight spacing wrong");
  AST_PWM_SET_HIGH: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && is_pwm && at_top && st.com[1] == `TMW_COM_CLEAR)
    |=> wave_out_b)
    else $error("output b not restored at counter clear");

  // further checks on the counter, the flags and the pins
  // a compare value equal to the ceiling: the clear at the match and the
  // set at the counter clear fall on one tick, so the level never drops
  AST_PWM_HOLD_C: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && is_pwm && at_top && st.com[2] == `TMW_COM_CLEAR
     && st.ocr_act[2] == top)
    |=> wave_out_c)
    else $error("output c not held at compare equal to ceiling");

  // a count write wins over a tick, so every step check leaves it out
  AST_PWM_WRAP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && is_pwm && at_top && !(wr_go && wsel == 3'h1))
    |=> st.cnt == `TMW_FLOOR)
    else $error("fast pwm did not return to the floor");

  AST_CAP_FLAG: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && st.mode == `TMW_MODE_CTC_CAP && st.cnt == st.cap)
    |=> st.flags[`TMW_FLG_CAPTURE])
    else $error("capture flag missed at ceiling");

  // only a software write of one may lower the overflow flag; counting
  // alone keeps it up, which is what makes it usable as a seventeenth bit
  AST_OVF_STICKY: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st.flags[`TMW_FLG_OVF] && !(wr_go && wsel == 3'h6))
    |=> st.flags[`TMW_FLG_OVF])
    else $error("overflow flag dropped without a clear");

  // with the count clock stopped only software moves the count
  AST_STOP_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st.csel == `TMW_CSEL_STOP && !(wr_go && wsel == 3'h1))
    |=> $stable(st.cnt))
    else $error("count moved with the count clock stopped");

  // a pin edge counts once, two clocks after it reaches the first stage;
  // the pin is not filtered, so a bouncing source counts every bounce
  AST_EXT_TICK: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st.csel == `TMW_CSEL_EXT_RISE && st.ext_s2 && !st.ext_s3 && !is_ctc
     && !is_pwm && !(wr_go && wsel == 3'h1))
    |=> st.cnt == $past(st.cnt) + 16'h0001)
    else $error("external rising edge not counted");

endmodule

`default_nettype wire

// File: dv/tmw_wave_load.sv
`timescale 1ns/1ps
`default_nettype none

// pin load on the three waveform outputs: counts cycles spent high
module tmw_wave_load
  import tmw_pkg::*;
(
  input  wire logic        clk_sys, // system clock
  input  wire logic        nrst,    // async reset, active low
  input  wire logic [2:0]  wave,    // wave_out_c..a as seen at the pins
  input  wire logic        meas,    // count only while high
  input  wire logic        clr,     // zero the counters
  output logic [2:0][15:0] hi_cnt   // high-cycle count per output
);
  // a load has no memory of its own; the counter just integrates duty
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hi_cnt <= '0;
    end else if (clr) begin
      hi_cnt <= '0;
    end else if (meas) begin
      for (int i = 0; i < 3; i++) begin
        hi_cnt[i] <= hi_cnt[i] + {15'h0000, wave[i]};
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/tmw_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmw_params.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end

module tmw_timer_tb
  import tmw_pkg::*;
;
  logic clk_sys, nrst, ext_clk_pin, meas, clr;                // clock, reset, stimulus
  logic [4:0] s_axi_awaddr, s_axi_araddr;                     // bus addresses
  logic [31:0] s_axi_wdata, s_axi_rdata, d;                   // bus data, read result
  logic [3:0] s_axi_wstrb;                                    // byte enables
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;                       // responses
  logic wave_out_a, wave_out_b, wave_out_c;                   // waveform pins
  logic [2:0][15:0] hi_cnt;                                   // load duty counts
  int n_errors, total_checks;                                 // verdict counters

  tmw_timer dut_u (.clk_sys, .nrst, .ext_clk_pin, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wave_out_a, .wave_out_b, .wave_out_c);
  tmw_wave_load load_u (.clk_sys, .nrst, .meas, .clr, .hi_cnt,
    .wave({wave_out_c, wave_out_b, wave_out_a}));

  // free-running system clock, 100 ns
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a bounded wait that ran out ends the run as a failure
  task automatic tmo(input int n);
    if (n >= 50) begin
      n_errors++;
      final_report();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // control word: mode, clock select, compare output modes a and b
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic [2:0] cs,
                                      input logic [1:0] ca, input logic [1:0] cb);
    ctl = {20'h00000, cb, ca, 1'b0, cs, m};
  endfunction

  // write: address and data offered together, held until taken
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (s_axi_awready !== 1'b1 && n < 50);
    tmo(n);
    `CHK(s_axi_wready, 1'b1)
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (s_axi_bvalid !== 1'b1 && n < 50);
    tmo(n);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  // read: result lands in d
  task automatic rd(input logic [4:0] a, input logic [1:0] er = 2'h0);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (s_axi_arready !== 1'b1 && n < 50);
    tmo(n);
    s_axi_arvalid <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (s_axi_rvalid !== 1'b1 && n < 50);
    tmo(n);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    `CHK(s_axi_rresp, er)
  endtask

  // reset state, then an unmapped place answers with an error
  task automatic t_reset();
    `CHK({wave_out_c, wave_out_b, wave_out_a}, 3'h0)
    rd(`TMW_OFF_CTRL);
    `CHK(d, 32'h00000000)
    rd(`TMW_OFF_FLAGS);
    `CHK(d, 32'h00000000)
    rd(5'h1C, `TMW_RESP_SLVERR);
    `CHK(d, 32'h00000000)
    wr(5'h1C, 32'h0000FFFF, `TMW_RESP_SLVERR);
  endtask

  // wrap through 0xFFFF with a toggle match on the way; odd modes act the same
  task automatic t_normal(input logic [3:0] m, input logic wa);
    wr(`TMW_OFF_CTRL, 32'h00000000);
    wr(`TMW_OFF_COUNT, 32'h0000FFF0);
    wr(`TMW_OFF_CMP_A, 32'h0000FFF8);
    wr(`TMW_OFF_FLAGS, 32'h0000001F);
    rd(`TMW_OFF_COUNT);
    `CHK(d, 32'h0000FFF0)
    wr(`TMW_OFF_CTRL, ctl(m, `TMW_CSEL_DIV1, `TMW_COM_TOGGLE, 2'h0));
    cyc(30);
    wr(`TMW_OFF_CTRL, ctl(m, `TMW_CSEL_STOP, `TMW_COM_TOGGLE, 2'h0));
    rd(`TMW_OFF_COUNT);
    `CHK(d < 32'h00000040, 1'b1)
    rd(`TMW_OFF_FLAGS);
    `CHK(d[`TMW_FLG_OVF], 1'b1)
    `CHK(wave_out_a, wa)
    wr(`TMW_OFF_FLAGS, 32'h00000001);
    rd(`TMW_OFF_FLAGS);
    `CHK(d[`TMW_FLG_OVF], 1'b0)
  endtask

  // clear at ceiling 9, then a count above the ceiling misses the match
  task automatic t_ctc(input logic [3:0] m, input logic [4:0] off, input int fb);
    // mode set first, clock stopped, so the ceiling write lands in clear-on-match
    wr(`TMW_OFF_CTRL, ctl(m, `TMW_CSEL_STOP, 2'h0, 2'h0));
    wr(`TMW_OFF_COUNT, 32'h00000000);
    wr(off, 32'h00000009);
    wr(`TMW_OFF_FLAGS, 32'h0000001F);
    wr(`TMW_OFF_CTRL, ctl(m, `TMW_CSEL_DIV1, 2'h0, 2'h0));
    cyc(100);
    wr(`TMW_OFF_CTRL, ctl(m, `TMW_CSEL_STOP, 2'h0, 2'h0));
    rd(`TMW_OFF_COUNT);
    `CHK(d <= 32'h00000009, 1'b1)
    rd(`TMW_OFF_FLAGS);
    `CHK(d[fb], 1'b1)
    `CHK(d[`TMW_FLG_OVF], 1'b0)
    wr(`TMW_OFF_COUNT, 32'h00000014);
    wr(`TMW_OFF_FLAGS, 32'h0000001F);
    wr(`TMW_OFF_CTRL, ctl(m, `TMW_CSEL_DIV1, 2'h0, 2'h0));
    cyc(20);
    wr(`TMW_OFF_CTRL, ctl(m, `TMW_CSEL_STOP, 2'h0, 2'h0));
    rd(`TMW_OFF_COUNT);
    `CHK(d > 32'h00000014, 1'b1)
    rd(`TMW_OFF_FLAGS);
    `CHK(d[fb], 1'b0)
  endtask

  // fast pwm with ceiling 0x3F from compare a; duty measured at the load
  task automatic t_fast();
    wr(`TMW_OFF_CTRL, 32'h00000000);
    wr(`TMW_OFF_COUNT, 32'h00000000);
    wr(`TMW_OFF_CMP_A, 32'h0000003F);
    wr(`TMW_OFF_CMP_B, 32'h00000010);
    wr(`TMW_OFF_CMP_C, 32'h0000003F);
    wr(`TMW_OFF_FLAGS, 32'h0000001F);
    // channel c clears on match and sets at clear, compare equal to ceiling
    wr(`TMW_OFF_CTRL, ctl(`TMW_MODE_FASTA, `TMW_CSEL_DIV1, `TMW_COM_TOGGLE, `TMW_COM_CLEAR)
       | {18'h00000, `TMW_COM_CLEAR, 12'h000});
    cyc(140);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    meas <= 1'b1;
    cyc(512);
    meas <= 1'b0;
    cyc(1);
    // 4 whole toggle periods of 128 give exactly half
    `CHK(hi_cnt[0], 16'h0100)
    // b high from the clear through its match at 0x10: 17 of every 64 counts
    `CHK(hi_cnt[1], 16'h0088)
    `CHK(hi_cnt[2], 16'h0200)
    wr(`TMW_OFF_CTRL, ctl(`TMW_MODE_FASTA, `TMW_CSEL_STOP, 2'h0, 2'h0));
    rd(`TMW_OFF_COUNT);
    `CHK(d <= 32'h0000003F, 1'b1)
    rd(`TMW_OFF_FLAGS);
    `CHK(d[`TMW_FLG_OVF], 1'b1)
    wr(`TMW_OFF_COUNT, 32'h000000F0);
    wr(`TMW_OFF_CTRL, ctl(`TMW_MODE_FAST8, `TMW_CSEL_DIV1, 2'h0, 2'h0));
    cyc(40);
    wr(`TMW_OFF_CTRL, ctl(`TMW_MODE_FAST8, `TMW_CSEL_STOP, 2'h0, 2'h0));
    rd(`TMW_OFF_COUNT);
    `CHK(d < 32'h00000040, 1'b1)
  endtask

  // each divider gives about four ticks in four periods; slack for bus time
  task automatic t_presc();
    int dv [4] = '{8, 64, 256, 1024};
    for (int i = 0; i < 4; i++) begin
      wr(`TMW_OFF_COUNT, 32'h00000000);
      wr(`TMW_OFF_CTRL, ctl(4'h0, 3'(i + 2), 2'h0, 2'h0));
      cyc(dv[i] * 4);
      wr(`TMW_OFF_CTRL, 32'h00000000);
      rd(`TMW_OFF_COUNT);
      `CHK(d >= 32'h00000003 && d <= 32'h00000005, 1'b1)
    end
  endtask

  // five pin pulses counted on rising, then on falling edges
  task automatic t_ext();
    for (int s = 6; s < 8; s++) begin
      wr(`TMW_OFF_COUNT, 32'h00000000);
      wr(`TMW_OFF_CTRL, ctl(4'h0, 3'(s), 2'h0, 2'h0));
      repeat (5) begin
        ext_clk_pin <= 1'b1;
        cyc(4);
        ext_clk_pin <= 1'b0;
        cyc(4);
      end
      wr(`TMW_OFF_CTRL, 32'h00000000);
      rd(`TMW_OFF_COUNT);
      `CHK(d, 32'h00000005)
    end
  endtask

  // main sequence: inputs idle, reset 3 cycles, then every scenario
  initial begin
    {nrst, ext_clk_pin, meas, clr, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    n_errors = 0;
    total_checks = 0;
    cyc(3);
    nrst <= 1'b1;
    t_reset();
    t_normal(`TMW_MODE_NORMAL, 1'b1);
    t_normal(4'h1, 1'b0);
    t_ctc(`TMW_MODE_CTC_A, `TMW_OFF_CMP_A, `TMW_FLG_CMP_A);
    t_ctc(`TMW_MODE_CTC_CAP, `TMW_OFF_CAPTURE, `TMW_FLG_CAPTURE);
    t_fast();
    t_presc();
    t_ext();
    final_report();
  end
endmodule
`default_nettype wire
